/* File: src/registered_prom_program_control.sv */
`include "prom_consts.svh"

// Function
// - Register clock rising edge loads output register from array word.
// - Extra initialize byte loads into output register on initialize.
// - Unprogrammed initialize byte is zero, so initialize clears register.
// - Supervoltage on A1 with A2 low selects initialize byte to program.
// - Initialize byte is verified by an initialize operation, not a read.
// - Erased array word holds neither one nor zero.
// - Blank check: virgin reads ones in ones mode, zeros in zeros mode.
// - Initialize loads both register stages at once, regardless of clock.
module registered_prom_program_control
  import prom_pkg::*;
#(
  parameter int ADDR_W = `PROM_ADDR_W,
  parameter int DATA_W = `PROM_DATA_W
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] addr_pin,
  input wire logic [DATA_W-1:0] data_pin_in,
  output logic [DATA_W-1:0] data_pin_out,
  output logic data_pin_oe_n,
  input wire logic register_clock,
  input wire logic sync_out_en_n,
  input wire logic init_n,
  input wire logic async_out_en_n,
  input wire logic clock_pin_super_voltage_level,
  input wire logic init_pin_super_voltage_level,
  input wire logic a1_pin_super_voltage_level
);

  localparam int SW = ADDR_W + DATA_W + 7;

  // ========================================================
  // Pin synchroniser
  logic [SW-1:0] pins_raw;
  logic [SW-1:0] sync1_q;
  logic [SW-1:0] sync2_q;

  assign pins_raw = {addr_pin, data_pin_in, register_clock, sync_out_en_n,
                     init_n, async_out_en_n, clock_pin_super_voltage_level,
                     init_pin_super_voltage_level,
                     a1_pin_super_voltage_level};

  // Two flip-flops on every pin
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else
    begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
    end
  end

  logic [ADDR_W-1:0] addr_s;
  logic [DATA_W-1:0] din_s;
  logic program_strobe_n;
  logic verify_strobe_n;
  logic init_s;
  logic async_s;
  logic clk_hv;
  logic init_hv;
  logic a1_hv;

  // Shared pins carry two names depending on mode
  assign {addr_s, din_s, program_strobe_n, verify_strobe_n, init_s, async_s,
          clk_hv, init_hv, a1_hv} = sync2_q;

  // ========================================================
  // Mode decode
  function automatic prom_mode_t decode_mode(input logic ihv, input logic chv,
                                             input logic prog_n,
                                             input logic ver_n);
    prom_mode_t m;
    m = MODE_READ;
    if (ihv)
    begin
      if (!prog_n && ver_n)
      begin
        m = MODE_PROG;
      end
      else if (prog_n && !ver_n)
      begin
        m = MODE_VERIFY;
      end
      else
      begin
        m = MODE_INHIBIT;
      end
    end
    else if (chv)
    begin
      m = ver_n ? MODE_BLANK0 : MODE_BLANK1;
    end
    return m;
  endfunction

  prom_mode_t mode_q;
  prom_mode_t mode_d;

  assign mode_d = decode_mode(init_hv, clk_hv, program_strobe_n,
                              verify_strobe_n);

  // Mode register
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_q <= MODE_READ;
    end
    else
    begin
      mode_q <= mode_d;
    end
  end

  // ========================================================
  // Edge detection of the shared clock / strobe pin
  logic clk_prev_q;
  logic clk_rise;
  logic strobe_fall;
  logic init_act;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clk_prev_q <= 1'b0;
    end
    else
    begin
      clk_prev_q <= program_strobe_n;
    end
  end

  assign clk_rise = (mode_q == MODE_READ) && program_strobe_n && !clk_prev_q;
  // Strobe falls on entry into program mode from inhibit or verify
  assign strobe_fall = (mode_d == MODE_PROG) && clk_prev_q
                       && (mode_q == MODE_INHIBIT || mode_q == MODE_VERIFY);
  // initialize reads the byte back; ignored outside read mode
  assign init_act = (mode_d == MODE_READ) && !init_s;

  // ========================================================
  // Array and programming writes
  prom_array_if arr ();
  logic init_wr;
  logic [DATA_W-1:0] init_byte_q;
  logic init_touched_q;

  prom_array prom_array_inst (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .bus(arr.ctrl)
  );

  // supervoltage on A1 with A2 low targets the initialize byte
  assign init_wr = strobe_fall && a1_hv && !addr_s[`PROM_INIT_SEL_BIT];
  assign arr.rd_addr = addr_s;
  assign arr.wr_en = strobe_fall && !init_wr;
  assign arr.wr_addr = addr_s;
  assign arr.wr_data = din_s;

  // initialize byte ships erased as zeros
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      init_byte_q <= `PROM_INIT_ERASED;
      init_touched_q <= 1'b0;
    end
    else if (init_wr)
    begin
      init_byte_q <= din_s;
      init_touched_q <= 1'b1;
    end
  end

  // ========================================================
  // Output register: master and slave stages, sync enable flop
  logic [DATA_W-1:0] master_q;
  logic [DATA_W-1:0] slave_q;
  logic en_q;

  // initialize loads master ahead of the addressed word
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      master_q <= `PROM_INIT_ERASED;
    end
    else if (init_act)
    begin
      master_q <= init_byte_q;
    end
    else
    begin
      master_q <= arr.rd_prog ? arr.rd_word : `PROM_ERASED_READ;
    end
  end

  // clock edge moves master into slave; initialize wins
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      slave_q <= `PROM_INIT_ERASED;
    end
    else if (init_act)
    begin
      slave_q <= init_byte_q;
    end
    else if (clk_rise)
    begin
      slave_q <= master_q;
    end
  end

  // Sync enable flop starts set, outputs off
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      en_q <= 1'b1;
    end
    else if (clk_rise)
    begin
      en_q <= verify_strobe_n;
    end
  end

  // ========================================================
  // Output drive per mode
  logic [DATA_W-1:0] out_d;
  logic oe_n_d;

  always_comb
  begin
    out_d = slave_q;
    oe_n_d = 1'b1;
    unique case (mode_q)
      MODE_READ:
      begin
        oe_n_d = en_q || async_s;
      end
      MODE_VERIFY:
      begin
        out_d = arr.rd_prog ? arr.rd_word : `PROM_ERASED_READ;
        oe_n_d = 1'b0;
      end
      // erased words read per blank-check mode
      MODE_BLANK1:
      begin
        out_d = arr.rd_prog ? arr.rd_word : `PROM_BLANK_ONES;
        oe_n_d = 1'b0;
      end
      MODE_BLANK0:
      begin
        out_d = arr.rd_prog ? arr.rd_word : `PROM_BLANK_ZEROS;
        oe_n_d = 1'b0;
      end
      MODE_PROG, MODE_INHIBIT:
      begin
        oe_n_d = 1'b1;
      end
      default:
      begin
        oe_n_d = 1'b1;
      end
    endcase
  end

  // Output pin flops
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      data_pin_out <= '0;
      data_pin_oe_n <= 1'b1;
    end
    else
    begin
      data_pin_out <= out_d;
      data_pin_oe_n <= oe_n_d;
    end
  end

  // ========================================================
  // Checks
  read_load_path_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    clk_rise && !init_act |=> slave_q == $past(master_q))
    else $error("clock edge did not load output register");

  init_both_stages_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    init_act |=> (slave_q == init_byte_q) && (master_q == init_byte_q))
    else $error("initialize did not load both stages");

  init_to_pins_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    init_act && !async_s && !en_q ##1 mode_q == MODE_READ
    |=> data_pin_out == $past(init_byte_q, 2))
    else $error("initialize byte not shown on outputs");

  init_erased_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    !init_touched_q |-> init_byte_q == `PROM_INIT_ERASED)
    else $error("unprogrammed initialize byte not zero");

  init_select_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    $changed(init_byte_q) |-> $past(init_wr) && !$past(arr.wr_en))
    else $error("initialize byte changed without its address");

  blank_ones_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    mode_q == MODE_BLANK1 && !arr.rd_prog
    |=> data_pin_out == `PROM_BLANK_ONES && !data_pin_oe_n)
    else $error("erased word not ones in ones blank check");

  blank_zeros_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    mode_q == MODE_BLANK0 && !arr.rd_prog
    |=> data_pin_out == `PROM_BLANK_ZEROS && !data_pin_oe_n)
    else $error("erased word not zeros in zeros blank check");

  prog_hiz_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (mode_q == MODE_PROG || mode_q == MODE_INHIBIT) |=> data_pin_oe_n)
    else $error("outputs driven during program or inhibit");

  sync_disable_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    clk_rise && verify_strobe_n ##1 mode_q == MODE_READ |=> data_pin_oe_n)
    else $error("sync enable high did not disable outputs");

endmodule

/* File: inc/prom_consts.svh */
`ifndef PROM_CONSTS_SVH
`define PROM_CONSTS_SVH

// ==========================================================
// Array geometry
`define PROM_ADDR_W 10
`define PROM_DATA_W 8
`define PROM_DEPTH 1024

// ==========================================================
// Data values
`define PROM_INIT_ERASED 8'h00
`define PROM_BLANK_ONES 8'hFF
`define PROM_BLANK_ZEROS 8'h00
`define PROM_ERASED_READ 8'h00

// ==========================================================
// Address bit that must be low to reach the initialize byte
`define PROM_INIT_SEL_BIT 2

`endif

/* File: inc/prom_pkg.sv */
package prom_pkg;

  // ========================================================
  // Operating modes, one-hot
  typedef enum logic [5:0] {
    MODE_READ    = 6'h01,
    MODE_PROG    = 6'h02,
    MODE_VERIFY  = 6'h04,
    MODE_INHIBIT = 6'h08,
    MODE_BLANK1  = 6'h10,
    MODE_BLANK0  = 6'h20
  } prom_mode_t;

endpackage

/* File: inc/prom_array_if.sv */
`include "prom_consts.svh"

interface prom_array_if;
  logic [`PROM_ADDR_W-1:0] rd_addr;
  logic [`PROM_DATA_W-1:0] rd_word;
  logic rd_prog;
  logic wr_en;
  logic [`PROM_ADDR_W-1:0] wr_addr;
  logic [`PROM_DATA_W-1:0] wr_data;

  modport ctrl (output rd_addr, output wr_en, output wr_addr,
                output wr_data, input rd_word, input rd_prog);
  modport mem (input rd_addr, input wr_en, input wr_addr,
               input wr_data, output rd_word, output rd_prog);
endinterface

/* File: src/prom_array.sv */
`include "prom_consts.svh"

module prom_array #(
  parameter int DEPTH = `PROM_DEPTH
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  prom_array_if.mem bus
);

  logic [`PROM_DATA_W-1:0] mem_q [DEPTH];
  logic [DEPTH-1:0] prog_q;

  // ========================================================
  // Word storage, written by program pulses
  always_ff @(posedge ref_clk)
  begin
    if (bus.wr_en)
    begin
      mem_q[bus.wr_addr] <= bus.wr_data;
    end
  end

  // ========================================================
  // Per-word programmed flag; erased words have no value
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prog_q <= '0;
    end
    else if (bus.wr_en)
    begin
      prog_q[bus.wr_addr] <= 1'b1;
    end
  end

  // Combinational read of the addressed word
  assign bus.rd_word = mem_q[bus.rd_addr];
  assign bus.rd_prog = prog_q[bus.rd_addr];

endmodule

/* File: dv/prog_host.sv */
// ==========================================
// Host and programmer driving the PROM pins
module prog_host #(
  parameter int PULSE = 4
) (
  input wire logic ref_clk,
  input wire logic [7:0] data_pin_out,
  input wire logic data_pin_oe_n,
  output logic [9:0] addr_pin,
  output logic [7:0] data_pin_in,
  output logic register_clock,
  output logic sync_out_en_n,
  output logic init_n,
  output logic async_out_en_n,
  output logic clock_pin_super_voltage_level,
  output logic init_pin_super_voltage_level,
  output logic a1_pin_super_voltage_level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic drive;
  logic [7:0] wdata;

  // Idle pin levels at time zero
  initial
  begin
    {addr_pin, wdata, drive, register_clock} = '0;
    data_pin_in = 8'h5A;
    {sync_out_en_n, init_n, async_out_en_n} = 3'h6;
    clock_pin_super_voltage_level = 1'b0;
    init_pin_super_voltage_level = 1'b0;
    a1_pin_super_voltage_level = 1'b0;
  end

  // Released data lines toggle every cycle
  always @(negedge ref_clk)
    data_pin_in <= drive ? wdata : ~data_pin_in;

  task step(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // One registered read in read mode
  task read_word(input logic [9:0] a, input logic sen,
                 output logic [7:0] d, output logic oe);
    addr_pin = a;
    register_clock = 1'b0;
    sync_out_en_n = sen;
    step(4);
    register_clock = 1'b1;
    step(6);
    d = data_pin_out;
    oe = data_pin_oe_n;
  endtask

  // Enter program inhibit from read mode
  task enter_prog();
    {register_clock, sync_out_en_n, init_n, async_out_en_n} = 4'hF;
    step(3);
    init_pin_super_voltage_level = 1'b1;
    step(4);
  endtask

  task leave_prog();
    init_pin_super_voltage_level = 1'b0;
    step(4);
  endtask

  // Write one byte with the fast method
  task prog_byte(input logic [9:0] a, input logic [7:0] d,
                 input logic a1, output logic [7:0] v);
    int n;
    addr_pin = a;
    a1_pin_super_voltage_level = a1;
    wdata = d;
    drive = 1'b1;
    step(4);
    n = 0;
    do
    begin
      register_clock = 1'b0;
      step(PULSE);
      register_clock = 1'b1;
      drive = 1'b0;
      step(3);
      sync_out_en_n = 1'b0;
      step(5);
      v = data_pin_out;
      sync_out_en_n = 1'b1;
      drive = 1'b1;
      step(4);
      n++;
    end
    while (v !== d && n < 4);
    register_clock = 1'b0;
    step(24 * n * PULSE);
    register_clock = 1'b1;
    step(4);
    a1_pin_super_voltage_level = 1'b0;
  endtask

  // Write one byte with a single long pulse
  task brute_byte(input logic [9:0] a, input logic [7:0] d,
                  output logic [7:0] v);
    addr_pin = a;
    wdata = d;
    drive = 1'b1;
    step(4);
    // one long pulse, then a single verify
    register_clock = 1'b0;
    step(100 * PULSE);
    register_clock = 1'b1;
    drive = 1'b0;
    step(3);
    sync_out_en_n = 1'b0;
    step(5);
    v = data_pin_out;
    sync_out_en_n = 1'b1;
    drive = 1'b1;
    step(4);
  endtask

  // Blank check one address
  task blank(input logic [9:0] a, input logic ones,
             output logic [7:0] d);
    addr_pin = a;
    sync_out_en_n = !ones;
    {init_n, async_out_en_n} = 2'h0;
    clock_pin_super_voltage_level = 1'b1;
    step(5);
    d = data_pin_out;
    init_n = 1'b1;
    clock_pin_super_voltage_level = 1'b0;
    step(3);
  endtask

  // Pulse initialize with outputs on
  task do_init(output logic [7:0] d, output logic oe);
    {init_n, async_out_en_n} = 2'h0;
    step(5);
    d = data_pin_out;
    oe = data_pin_oe_n;
    init_n = 1'b1;
    step(3);
  endtask
endmodule

/* File: dv/tb_registered_prom_program_control.sv */
// ==========================================
// Self-checking bench for the registered PROM
module tb_registered_prom_program_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rst_n, oe;
  logic [9:0] addr_pin, a;
  logic [9:0] al [5];
  logic [7:0] data_pin_in, data_pin_out, d, v, iv;
  logic data_pin_oe_n, register_clock, sync_out_en_n;
  logic init_n, async_out_en_n, clk_sv, init_sv, a1_sv;
  logic [7:0] wmem [int];
  int failures, num_checks;

  registered_prom_program_control registered_prom_program_control_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .addr_pin(addr_pin),
    .data_pin_in(data_pin_in), .data_pin_out(data_pin_out),
    .data_pin_oe_n(data_pin_oe_n), .register_clock(register_clock),
    .sync_out_en_n(sync_out_en_n), .init_n(init_n),
    .async_out_en_n(async_out_en_n),
    .clock_pin_super_voltage_level(clk_sv),
    .init_pin_super_voltage_level(init_sv),
    .a1_pin_super_voltage_level(a1_sv)
  );

  prog_host prog_host_inst (
    .ref_clk(ref_clk), .data_pin_out(data_pin_out),
    .data_pin_oe_n(data_pin_oe_n), .addr_pin(addr_pin),
    .data_pin_in(data_pin_in), .register_clock(register_clock),
    .sync_out_en_n(sync_out_en_n), .init_n(init_n),
    .async_out_en_n(async_out_en_n),
    .clock_pin_super_voltage_level(clk_sv),
    .init_pin_super_voltage_level(init_sv),
    .a1_pin_super_voltage_level(a1_sv)
  );

  // Expected read of an array word, erased reads zero
  function automatic logic [7:0] exp_read(input logic [9:0] x);
    return wmem.exists(x) ? wmem[x] : 8'h00;
  endfunction

  // Expected blank check value
  function automatic logic [7:0] exp_blank(input logic [9:0] x,
                                           input logic ones);
    if (wmem.exists(x))
      return wmem[x];
    return ones ? 8'hFF : 8'h00;
  endfunction

  task chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task blank_all();
    for (int i = 0; i < 5; i++)
    begin
      prog_host_inst.blank(al[i], 1'b1, d);
      chk(d, exp_blank(al[i], 1'b1));
      prog_host_inst.blank(al[i], 1'b0, d);
      chk(d, exp_blank(al[i], 1'b0));
    end
  endtask

  task end_sim();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Clock generation
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // Watchdog
  initial
  begin
    #(20000 * 25);
    failures++;
    end_sim();
  end

  // Main sequence
  initial
  begin
    void'($urandom(32'h2d8b72e6));
    failures = 0;
    num_checks = 0;
    rst_n = 1'b0;
    al[0] = 10'h000;
    al[1] = 10'h3FF;
    for (int i = 2; i < 5; i++)
      al[i] = 10'($urandom_range(4, 1019));
    repeat (8) @(posedge ref_clk);
    @(negedge ref_clk) rst_n = 1'b1;
    prog_host_inst.read_word(10'h007, 1'b1, d, oe);
    chk({7'h00, oe}, 8'h01);
    prog_host_inst.read_word(al[2], 1'b0, d, oe);
    chk(d, exp_read(al[2]));
    chk({7'h00, oe}, 8'h00);
    prog_host_inst.do_init(d, oe);
    chk(d, 8'h00);
    blank_all();
    prog_host_inst.enter_prog();
    chk({7'h00, data_pin_oe_n}, 8'h01);
    for (int i = 0; i < 4; i++)
    begin
      d = 8'($urandom);
      prog_host_inst.prog_byte(al[i], d, 1'b0, v);
      wmem[al[i]] = d;
      chk(v, d);
    end
    d = 8'($urandom);
    prog_host_inst.brute_byte(al[4], d, v);
    wmem[al[4]] = d;
    chk(v, d);
    a = 10'($urandom) & 10'h3FB;
    iv = 8'($urandom);
    prog_host_inst.prog_byte(a, iv, 1'b1, v);
    prog_host_inst.leave_prog();
    for (int i = 0; i < 5; i++)
    begin
      prog_host_inst.read_word(al[i], 1'b0, d, oe);
      chk(d, exp_read(al[i]));
    end
    prog_host_inst.read_word(a, 1'b0, d, oe);
    chk(d, exp_read(a));
    blank_all();
    prog_host_inst.do_init(d, oe);
    chk(d, iv);
    chk({7'h00, oe}, 8'h00);
    prog_host_inst.async_out_en_n = 1'b1;
    prog_host_inst.step(5);
    chk({7'h00, data_pin_oe_n}, 8'h01);
    end_sim();
  end
endmodule
